/* File: cvsd_slope_core.sv */
// Notes on behaviour
// [R1] Serial output changes only at a bit clock falling edge, steady between.
// [R2] Encode: output high when feedback exceeds analog input.
// [R3] Coincidence low while history is all ones or all zeros.
// [R4] History length is a build parameter, three or four stages.
// [R5] Encode select high shifts comparator result, low shifts data input.
// [R6] Data input appears complemented at the serial output.
// [R7] Output looped to data input in decode gives a toggling idle pattern.
// [R8] History advances one stage per falling edge, dropping the oldest bit.
// [R9] Exactly one serial bit per bit clock period.
// [R10] Idle encode loop settles to alternating one, zero output.
// [R11] Slope direction equals the current sign bit.
// [R12] Signalling is forced by far side via data input with decode selected.
// [R13] Adaptation uses only past history bits; no rate change, no framing.
// [R14] Decode: data high steers current into integrator, low out of it.
// [R15] Reset loads an alternating history so coincidence starts inactive.
`include "cvsd_consts.svh"

module cvsd_slope_core #(
   parameter int HIST_LEN = `CVSD_HIST_LEN_TEL,
   parameter int TAP_DEPTH = `CVSD_TAP_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Codec pins, asynchronous to ref_clk
   input wire logic bit_clk,
   input wire logic ain_above_fb,
   input wire logic data_in,
   input wire cvsd_pkg::cvsd_mode_t mode_sel,
   // Codec outputs
   output logic serial_out,
   output logic slope_dir,
   output logic coinc_b,
   output logic bclk_runt,
   // Bit tap toward on-chip logic
   output logic [`CVSD_TAP_WIDTH-1:0] tap_data,
   output logic tap_valid,
   input wire logic tap_ready,
   output logic tap_room,
   output logic tap_overrun
);
   import cvsd_pkg::*;

   localparam int HI_MIN_CYC = (`CVSD_BCLK_HI_MIN_NS + `CVSD_REF_PERIOD_NS - 1)
      / `CVSD_REF_PERIOD_NS;
   localparam int LO_MIN_CYC = (`CVSD_BCLK_LO_MIN_NS + `CVSD_REF_PERIOD_NS - 1)
      / `CVSD_REF_PERIOD_NS;
   localparam int CW = $clog2(LO_MIN_CYC + 1);
   localparam logic [HIST_LEN-1:0] HIST_RST = HIST_LEN'(`CVSD_HIST_RST_PAT);

   generate
      if (HIST_LEN != `CVSD_HIST_LEN_GEN && HIST_LEN != `CVSD_HIST_LEN_TEL) begin : g_bad
         $error("cvsd_slope_core history length must be 3 or 4"); // [R4]
      end
   endgenerate

   // Two-stage synchronisers for all pin inputs
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic bclk_s;
   logic ain_s;
   logic din_s;
   cvsd_mode_t mode_s;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else begin
         sync1_r <= {bit_clk, ain_above_fb, data_in, mode_sel};
         sync2_r <= sync1_r;
      end
   end

   assign bclk_s = sync2_r[3];
   assign ain_s = sync2_r[2];
   assign din_s = sync2_r[1];
   assign mode_s = cvsd_mode_t'(sync2_r[0]);

   // Bit clock phase tracking; a high phase shorter than the least width is
   // not trusted, so a short high pulse from noise on the clock pin cannot insert an extra bit.
   cvsd_bclk_st_t bst_r;
   logic [CW-1:0] ph_cnt_r;
   logic fall_evt;
   logic runt_r;

   assign fall_evt = (bst_r == CVSD_BCLK_HIGH) && !bclk_s;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         bst_r <= CVSD_BCLK_LOW;
         ph_cnt_r <= '0;
      end else begin
         case (bst_r)
            CVSD_BCLK_LOW: begin
               if (bclk_s) begin
                  bst_r <= (ph_cnt_r >= CW'(LO_MIN_CYC)) ? CVSD_BCLK_RUNT
                     : CVSD_BCLK_RUNT;
                  ph_cnt_r <= CW'(1);
               end else if (ph_cnt_r != '1) begin
                  ph_cnt_r <= ph_cnt_r + CW'(1);
               end
            end
            CVSD_BCLK_RUNT: begin
               if (!bclk_s) begin
                  bst_r <= CVSD_BCLK_LOW;
                  ph_cnt_r <= '0;
               end else if (ph_cnt_r >= CW'(HI_MIN_CYC - 1)) begin
                  bst_r <= CVSD_BCLK_HIGH;
               end else begin
                  ph_cnt_r <= ph_cnt_r + CW'(1);
               end
            end
            CVSD_BCLK_HIGH: begin
               if (!bclk_s) begin
                  bst_r <= CVSD_BCLK_LOW;
                  ph_cnt_r <= '0;
               end
            end
            default: begin
               bst_r <= CVSD_BCLK_LOW;
               ph_cnt_r <= '0;
            end
         endcase
      end
   end

   // Sticky runt indication: a short high phase was dropped
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         runt_r <= 1'b0;
      end else if (bst_r == CVSD_BCLK_RUNT && !bclk_s) begin
         runt_r <= 1'b1;
      end
   end

   // Length of the current high run, read only by the checks below
   logic [CW-1:0] hi_run_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         hi_run_r <= '0;
      end else if (!bclk_s) begin
         hi_run_r <= '0;
      end else if (hi_run_r != '1) begin
         hi_run_r <= hi_run_r + CW'(1);
      end
   end

   // Sign selection
   logic sign_nxt;
   always_comb begin
      if (mode_s == CVSD_ENCODE) begin
         sign_nxt = !ain_s; // [R2] [R5] [R10]
      end else begin
         sign_nxt = !din_s; // [R5] [R6] [R7] [R14]
      end
   end

   logic out_r;
   logic slope_r;
   logic [HIST_LEN-1:0] hist_r;
   logic coinc_b_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         out_r <= 1'b0;
         slope_r <= 1'b0;
      end else if (fall_evt) begin
         out_r <= sign_nxt; // [R1] [R9]
         slope_r <= sign_nxt; // [R11] [R14]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         hist_r <= HIST_RST; // [R15]
      end else if (fall_evt) begin
         hist_r <= {hist_r[HIST_LEN-2:0], sign_nxt}; // [R8] [R13]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         coinc_b_r <= 1'b1;
      end else begin
         coinc_b_r <= !((&hist_r) || !(|hist_r)); // [R3]
      end
   end

   // Tap buffer; the bit clock cannot be stalled, so a full buffer drops the
   // bit and flags it rather than disturbing the channel rate.
   cvsd_fifo_if #(.WIDTH(`CVSD_TAP_WIDTH)) tap_if ();
   logic push_r;
   logic [`CVSD_TAP_WIDTH-1:0] push_data_r;
   logic ovr_r;
   logic room_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         push_r <= 1'b0;
         push_data_r <= '0;
      end else begin
         push_r <= fall_evt; // [R9] [R13]
         push_data_r[`CVSD_TAP_SIGN_POS] <= sign_nxt;
         push_data_r[`CVSD_TAP_COINC_POS] <= coinc_b_r;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ovr_r <= 1'b0;
         room_r <= 1'b1;
      end else begin
         room_r <= tap_if.push_ready;
         if (push_r && !tap_if.push_ready) begin
            ovr_r <= 1'b1;
         end
      end
   end

   assign tap_if.push_valid = push_r;
   assign tap_if.push_data = push_data_r;
   assign tap_if.pop_ready = tap_ready;

   cvsd_fifo #(
      .WIDTH(`CVSD_TAP_WIDTH),
      .DEPTH(TAP_DEPTH)
   ) u_tap_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .fif(tap_if.fifo_side)
   );

   assign serial_out = out_r;
   assign slope_dir = slope_r;
   assign coinc_b = coinc_b_r;
   assign bclk_runt = runt_r;
   assign tap_data = tap_if.pop_data;
   assign tap_valid = tap_if.pop_valid;
   assign tap_room = room_r;
   assign tap_overrun = ovr_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence seq_loop_fall;
      fall_evt && mode_s == CVSD_DECODE && din_s == out_r;
   endsequence

   chk_out_steady: assert property (!fall_evt |=> $stable(out_r)) // [R1]
      else $error("serial output moved without a falling edge");
   chk_enc_sign: assert property ( // [R2]
      fall_evt && mode_s == CVSD_ENCODE |=> out_r == !$past(ain_s))
      else $error("encode output is not the comparator sign");
   chk_coinc_level: assert property ( // [R3]
      ##1 coinc_b_r == !($past(hist_r) == '0 || $past(hist_r) == '1))
      else $error("coincidence does not match history");
   chk_dec_invert: assert property ( // [R6]
      fall_evt && mode_s == CVSD_DECODE |=> out_r == !$past(din_s))
      else $error("decode output is not the inverted data input");
   chk_toggle_loop: assert property ( // [R7]
      seq_loop_fall |=> out_r != $past(out_r))
      else $error("looped decode did not toggle");
   chk_hist_shift: assert property ( // [R8]
      fall_evt |=> hist_r == {$past(hist_r[HIST_LEN-2:0]), out_r})
      else $error("history did not shift in the new bit");
   chk_one_bit: assert property (fall_evt |=> !fall_evt ##1 push_r == 1'b0) // [R9]
      else $error("more than one bit taken per clock period");
   chk_slope_sign: assert property (fall_evt |=> slope_r == out_r) // [R11]
      else $error("slope direction differs from sign bit");
   chk_no_insert: assert property (push_r |-> $past(fall_evt)) // [R13]
      else $error("tap word without a bit clock edge");
   chk_reset_alt: assert property ($rose(rst_b) |=> coinc_b_r) // [R15]
      else $error("coincidence active right after reset");

   // Bit clock filter, tap path, decode slope and reset history
   sequence seq_tap_word;
      push_r && push_data_r[`CVSD_TAP_SIGN_POS] == out_r;
   endsequence

   chk_fall_high_run: assert property (fall_evt |-> hi_run_r >= CW'(HI_MIN_CYC)) // [R9]
      else $error("bit taken after a short high phase");
   chk_tap_push: assert property (fall_evt |=> seq_tap_word) // [R9] [R13]
      else $error("accepted bit did not reach the tap");
   chk_runt_flag: assert property (bst_r == CVSD_BCLK_RUNT && !bclk_s |=> runt_r) // [R9]
      else $error("short high phase not flagged");
   chk_runt_sticky: assert property (runt_r |=> runt_r) // [R9]
      else $error("runt flag cleared without reset");
   chk_dec_slope: assert property ( // [R14]
      fall_evt && mode_s == CVSD_DECODE |=> slope_r == !$past(din_s))
      else $error("decode slope direction wrong");
   chk_drop_flag: assert property (push_r && !tap_if.push_ready |=> ovr_r) // [R13]
      else $error("dropped tap word not flagged");
   chk_ovr_sticky: assert property (ovr_r |=> ovr_r) // [R13]
      else $error("overrun flag cleared without reset");
   chk_reset_hist: assert property ($rose(rst_b) |-> hist_r == HIST_RST) // [R15]
      else $error("history not alternating after reset");
   chk_tap_coinc: assert property ( // [R3]
      push_r |-> push_data_r[`CVSD_TAP_COINC_POS] == coinc_b_r)
      else $error("tap coincidence bit is not the value before the bit");
endmodule

/* File: cvsd_consts.svh */
`ifndef CVSD_CONSTS_SVH
`define CVSD_CONSTS_SVH

// Local clock period in ns (100 MHz)
`define CVSD_REF_PERIOD_NS 10
// Least widths of the bit clock phases, in ns
`define CVSD_BCLK_HI_MIN_NS 300
`define CVSD_BCLK_LO_MIN_NS 900
// History register lengths of the two variants
`define CVSD_HIST_LEN_GEN 3
`define CVSD_HIST_LEN_TEL 4
// Alternating reset pattern, low bits are used
`define CVSD_HIST_RST_PAT 8'hAA
// Tap buffer shape
`define CVSD_TAP_DEPTH 8
`define CVSD_TAP_WIDTH 2
// Bit positions in a tap word
`define CVSD_TAP_SIGN_POS 0
`define CVSD_TAP_COINC_POS 1

`endif

/* File: cvsd_pkg.sv */
package cvsd_pkg;

   typedef enum logic {
      CVSD_DECODE = 1'b0,
      CVSD_ENCODE = 1'b1
   } cvsd_mode_t;

   typedef enum logic [1:0] {
      CVSD_BCLK_LOW = 2'b00,
      CVSD_BCLK_HIGH = 2'b01,
      CVSD_BCLK_RUNT = 2'b10
   } cvsd_bclk_st_t;

endpackage

/* File: cvsd_fifo_if.sv */
interface cvsd_fifo_if #(
   parameter int WIDTH = 2
);
   logic push_valid;
   logic push_ready;
   logic [WIDTH-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [WIDTH-1:0] pop_data;

   modport fifo_side (
      input push_valid, push_data, pop_ready,
      output push_ready, pop_valid, pop_data
   );
   modport user_side (
      output push_valid, push_data, pop_ready,
      input push_ready, pop_valid, pop_data
   );
endinterface

/* File: cvsd_fifo.sv */
`include "cvsd_consts.svh"

module cvsd_fifo #(
   parameter int WIDTH = `CVSD_TAP_WIDTH,
   parameter int DEPTH = `CVSD_TAP_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Both sides of the buffer
   cvsd_fifo_if.fifo_side fif
);
   import cvsd_pkg::*;

   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("cvsd_fifo depth must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic full_r;
   logic empty_r;
   logic do_push;
   logic do_pop;

   assign do_push = fif.push_valid && !full_r;
   assign do_pop = fif.pop_ready && !empty_r;
   assign fif.push_ready = !full_r;
   assign fif.pop_valid = !empty_r;
   assign fif.pop_data = mem_r[rd_r];

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_ent
         always_ff @(posedge ref_clk) begin
            if (!rst_b) begin
               mem_r[gi] <= '0;
            end else if (do_push && wr_r == AW'(gi)) begin
               mem_r[gi] <= fif.push_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (do_push) begin
            wr_r <= wr_r + AW'(1);
         end
         if (do_pop) begin
            rd_r <= rd_r + AW'(1);
         end
      end
   end

   // Flags are registered so neither side sees a combinational count compare
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cnt_r <= '0;
         full_r <= 1'b0;
         empty_r <= 1'b1;
      end else if (do_push && !do_pop) begin
         cnt_r <= cnt_r + (AW+1)'(1);
         full_r <= (cnt_r == (AW+1)'(DEPTH - 1));
         empty_r <= 1'b0;
      end else if (do_pop && !do_push) begin
         cnt_r <= cnt_r - (AW+1)'(1);
         full_r <= 1'b0;
         empty_r <= (cnt_r == (AW+1)'(1));
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   chk_fifo_count: assert property (full_r |-> cnt_r == (AW+1)'(DEPTH))
      else $error("fifo full flag disagrees with count");
endmodule

/* File: cvsd_chan_model.sv */
module cvsd_chan_model (
   // Clock
   input wire logic ref_clk,
   // Request from the bench
   input wire logic req,
   input wire logic [7:0] hi_len,
   input wire logic tx_bit,
   input wire logic loop_back,
   // Codec side, and the acknowledge back to the bench
   input wire logic serial_out,
   output logic bit_clk,
   output logic data_in,
   output logic ack
);
   timeunit 1ns;
   timeprecision 100ps;

   // Bit clock rests low between bits; the data line keeps its level
   // because the transmitter never releases it
   initial begin
      bit_clk = 1'b0;
      data_in = 1'b0;
      ack = 1'b0;
      forever begin
         @(posedge ref_clk);
         if (req) begin
            data_in <= loop_back ? serial_out : tx_bit;
            bit_clk <= 1'b1;
            repeat (hi_len) @(posedge ref_clk);
            bit_clk <= 1'b0;
            // Low phase long enough for the data hold time as well
            repeat (100) @(posedge ref_clk);
            ack <= 1'b1;
            @(posedge ref_clk);
            ack <= 1'b0;
         end
      end
   end
endmodule

/* File: tb_top.sv */
`include "cvsd_consts.svh"

`define CHK(g, e) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e); \
   end \
end

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import cvsd_pkg::*;

   logic ref_clk = 1'b0;
   logic rst_b, ain_above_fb, tap_ready, req, tx_bit, loop_back, hold_off, last_bit;
   logic bit_clk, data_in, serial_out, slope_dir, coinc_b, bclk_runt;
   logic tap_valid, tap_room, tap_overrun, ack;
   logic [`CVSD_TAP_WIDTH-1:0] tap_data;
   logic [7:0] hi_len;
   logic [3:0] hist, cur;
   logic [3:0] exp_q[$];
   cvsd_mode_t mode_sel;
   int failures = 0;
   int samples_checked = 0;
   int seed = 99252;
   int acc = 0;
   int i, n;

   always #5 ref_clk = ~ref_clk;

   cvsd_slope_core #(.HIST_LEN(4), .TAP_DEPTH(8)) DUT (
      .ref_clk(ref_clk), .rst_b(rst_b), .bit_clk(bit_clk),
      .ain_above_fb(ain_above_fb), .data_in(data_in), .mode_sel(mode_sel),
      .serial_out(serial_out), .slope_dir(slope_dir), .coinc_b(coinc_b),
      .bclk_runt(bclk_runt), .tap_data(tap_data), .tap_valid(tap_valid),
      .tap_ready(tap_ready), .tap_room(tap_room), .tap_overrun(tap_overrun)
   );

   cvsd_chan_model chan (
      .ref_clk(ref_clk), .req(req), .hi_len(hi_len), .tx_bit(tx_bit),
      .loop_back(loop_back), .serial_out(serial_out), .bit_clk(bit_clk),
      .data_in(data_in), .ack(ack)
   );

   task automatic close_out();
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // One bit through the channel; the expectation is noted before driving
   task automatic send(input cvsd_mode_t m, input logic a, input logic d,
                       input logic lp, input logic [7:0] hl, input logic live,
                       input logic want);
      logic b, cb;
      int k;
      b = lp ? ~last_bit : ((m == CVSD_ENCODE) ? ~a : ~d);
      if (hl >= 8'd30) begin
         cb = ~((&hist) | ~(|hist));
         hist = {hist[2:0], b};
         last_bit = b;
         if (want) begin
            exp_q.push_back({live, ~((&hist) | ~(|hist)), cb, b});
         end
      end
      @(posedge ref_clk);
      mode_sel <= m;
      ain_above_fb <= a;
      tx_bit <= d;
      loop_back <= lp;
      hi_len <= hl;
      req <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (ack !== 1'b1 && k < 400);
      req <= 1'b0;
      if (k >= 400) begin
         failures++;
         close_out();
      end
   endtask

   // Consumer of the tap stream, stalling at random
   always @(posedge ref_clk) begin
      tap_ready <= hold_off ? 1'b0 : 1'($random(seed));
   end

   always @(posedge ref_clk) begin
      if (rst_b === 1'b1 && tap_valid === 1'b1 && tap_ready === 1'b1) begin
         `CHK(exp_q.size() > 0, 1'b1)
         if (exp_q.size() > 0) begin
            cur = exp_q.pop_front();
            `CHK(tap_data, cur[1:0])
            if (cur[3]) begin
               `CHK(serial_out, cur[0])
               `CHK(slope_dir, cur[0])
               `CHK(coinc_b, cur[2])
            end
         end
      end
   end

   initial begin
      rst_b = 1'b0;
      mode_sel = CVSD_ENCODE;
      ain_above_fb = 1'b0;
      req = 1'b0;
      tx_bit = 1'b0;
      loop_back = 1'b0;
      hi_len = 8'd40;
      hold_off = 1'b0;
      hist = 4'hA;
      last_bit = 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      `CHK({serial_out, slope_dir, coinc_b, bclk_runt}, 4'h2)
      `CHK({tap_valid, tap_room, tap_overrun}, 3'h2)
      // Random modes and levels, one bit at the shortest legal high phase
      for (i = 0; i < 24; i++) begin
         send(cvsd_mode_t'(1'($random(seed))), 1'($random(seed)), 1'($random(seed)),
              1'b0, (i == 3) ? 8'd30 : 8'd40, 1'b1, 1'b1);
      end
      // Runs of equal bits raise and clear coincidence
      for (i = 0; i < 10; i++) begin
         send(CVSD_DECODE, 1'b0, (i >= 5), 1'b0, 8'h28, 1'b1, 1'b1);
      end
      // Idle encode loop with a simple integrator, then decode with the output looped back
      for (i = 0; i < 8; i++) begin
         send(CVSD_ENCODE, (acc < 0), 1'b0, 1'b0, 8'h28, 1'b1, 1'b1);
         acc = last_bit ? acc - 1 : acc + 1;
      end
      for (i = 0; i < 6; i++) begin
         send(CVSD_DECODE, 1'b0, 1'b0, 1'b1, 8'h28, 1'b1, 1'b1);
      end
      // A short high phase must not clock a bit
      send(CVSD_DECODE, 1'b0, 1'b1, 1'b0, 8'd10, 1'b1, 1'b1);
      `CHK(bclk_runt, 1'b1)
      // Stalled consumer: buffer fills, two bits are dropped
      @(posedge ref_clk);
      hold_off <= 1'b1;
      for (i = 0; i < 10; i++) begin
         send(CVSD_DECODE, 1'b0, i[0], 1'b0, 8'd40, 1'b0, (i < 8));
      end
      `CHK(tap_room, 1'b0)
      `CHK(tap_overrun, 1'b1)
      hold_off <= 1'b0;
      n = 0;
      while (exp_q.size() > 0 && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 300) begin
         failures++;
      end
      repeat (5) @(posedge ref_clk);
      `CHK({tap_valid, tap_room}, 2'h1)
      close_out();
   end
endmodule
